// ### macrocell_cfg.svh
// Named constants for the output macrocell bank
`ifndef MACROCELL_CFG_SVH
`define MACROCELL_CFG_SVH

// Bank geometry and product term distribution
`define CELL_COUNT        12
`define TERMS_WIDE        12
`define TERMS_MID         10
`define TERMS_BASE        8
`define WIDE_CELLS        2
`define MID_CELLS         2
`define LOGIC_TERMS_TOTAL 108

// Bus widths
`define ADDR_W            8
`define DATA_W            32

// Register byte addresses
`define REG_POL           8'h00
`define REG_MODE          8'h04
`define REG_OESEL         8'h08
`define REG_STATE         8'h0C
`define REG_PINS          8'h10

// Reset values
`define POL_RST           12'h000
`define MODE_RST          12'h000
`define OESEL_RST         24'h00_0000

// Combinatorial enable selector codes
`define OE_CODE_TERM      2'h0
`define OE_CODE_ON        2'h1
`define OE_CODE_OFF       2'h2

// Field position of enables in the pin status word
`define PINS_OE_LSB       16

`endif

// ### macrocell_pkg.sv
// Types shared by the output macrocell bank
`include "macrocell_cfg.svh"

package macrocell_pkg;

	// Enable source of a macrocell in combinatorial mode
	typedef enum logic [1:0] {
		OE_SEL_TERM = `OE_CODE_TERM,
		OE_SEL_ON   = `OE_CODE_ON,
		OE_SEL_OFF  = `OE_CODE_OFF
	} oe_sel_e;

	// One bit per macrocell
	typedef logic [`CELL_COUNT-1:0] cell_vec_t;

endpackage : macrocell_pkg

// ### sync_two_flop.sv
// Two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none

module sync_two_flop #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_r; // First stage, read only by the second

	// Both stages clear on reset; only the second stage is visible
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			dout   <= '0;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end

endmodule : sync_two_flop
`default_nettype wire

// ### output_macrocell.sv
// One output macrocell: sum term, flip-flop, polarity, enable and feedback
`timescale 1ns/1ps
`default_nettype none
`include "macrocell_cfg.svh"

module output_macrocell #(
	parameter int NTERMS = `TERMS_BASE
) (
	input  wire logic                   core_clk,
	input  wire logic                   clr,
	input  wire logic                   sync_set,
	input  wire logic [NTERMS-1:0]      terms,
	input  wire logic                   oe_term,
	input  wire logic                   mode_bit_low,
	input  wire logic                   mode_bit_high,
	input  wire macrocell_pkg::oe_sel_e oe_sel,
	input  wire logic                   pin_level,
	output logic                        q,
	output logic                        sum,
	output logic                        pin_out,
	output logic                        pin_oe,
	output logic                        fb_true,
	output logic                        fb_comp
);
	import macrocell_pkg::*;

	logic q_r;   // Flip-flop state
	logic q_nxt; // Next flip-flop state
	logic level; // Value before the polarity stage
	logic oe_comb; // Enable chosen for combinatorial mode

	// Sum of this cell's own logic terms
	assign sum = |terms;

	// Preset wins over the sum term at the edge
	assign q_nxt = sync_set ? 1'b1 : sum;

	// Clear acts at once, with no edge, on the internal state only
	always_ff @(posedge core_clk or posedge clr) begin
		if (clr) begin
			q_r <= 1'b0;
		end else begin
			q_r <= q_nxt;
		end
	end
	assign q = q_r;

	// High mode bit picks combinatorial, low mode bit picks true polarity
	assign level   = mode_bit_high ? sum : q_r;
	assign pin_out = mode_bit_low ? level : ~level;

	// Unused fourth selector code behaves as off
	assign oe_comb = (oe_sel == OE_SEL_ON) | ((oe_sel == OE_SEL_TERM) & oe_term);
	assign pin_oe  = mode_bit_high ? oe_comb : oe_term;

	// Registered cells feed back the inverted state, never the pin
	assign fb_true = mode_bit_high ? pin_level : ~q_r;
	assign fb_comp = ~fb_true;

endmodule : output_macrocell
`default_nettype wire

// ### pld_output_macrocell_bank.sv
// Bank of twelve output macrocells with an Avalon-MM configuration slave
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "macrocell_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - Two cells twelve terms, two ten, rest eight
// - Each cell has its own enable term
// - Per-cell polarity in both modes
// - One shared clear and preset term
// - Clear forces all flip-flops low immediately
// - Preset loads ones at next edge
// - Clear and preset act before polarity
// - Two mode bits per cell
// - Registered pin from flip-flop, enable term
// - Registered feedback from inverted state
// - Combinatorial pin from sum, no register
// - Combinatorial enable on, off or term
// - Combinatorial feedback from pin level
module pld_output_macrocell_bank #(
	parameter int NCELLS = `CELL_COUNT
) (
	input  wire logic                          core_clk,
	input  wire logic                          rst,
	input  wire logic [`ADDR_W-1:0]            avs_address,
	input  wire logic                          avs_read,
	input  wire logic                          avs_write,
	input  wire logic [`DATA_W-1:0]            avs_writedata,
	input  wire logic [3:0]                    avs_byteenable,
	output logic      [`DATA_W-1:0]            avs_readdata,
	output logic                               avs_waitrequest,
	input  wire logic [`LOGIC_TERMS_TOTAL-1:0] logic_terms,
	input  wire macrocell_pkg::cell_vec_t      oe_terms,
	input  wire logic                          async_zero_term,
	input  wire logic                          sync_set_term,
	input  wire macrocell_pkg::cell_vec_t      pin_in,
	output macrocell_pkg::cell_vec_t           pin_out,
	output macrocell_pkg::cell_vec_t           pin_oe,
	output macrocell_pkg::cell_vec_t           feedback_true,
	output macrocell_pkg::cell_vec_t           feedback_comp
);
	import macrocell_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Term layout

	// Number of logic terms a cell receives
	function automatic int term_cnt(input int idx);
		if (idx < `WIDE_CELLS) begin
			return `TERMS_WIDE;
		end else if (idx < `WIDE_CELLS + `MID_CELLS) begin
			return `TERMS_MID;
		end else begin
			return `TERMS_BASE;
		end
	endfunction : term_cnt

	// Position of a cell's first term in the packed term bus
	function automatic int term_off(input int idx);
		int acc;
		acc = 0;
		for (int k = 0; k < idx; k++) begin
			acc = acc + term_cnt(k);
		end
		return acc;
	endfunction : term_off

	// The term layout only fits the documented bank size
	if (NCELLS != `CELL_COUNT || term_off(NCELLS) != `LOGIC_TERMS_TOTAL) begin : g_bad_size
		$error("NCELLS must match the fixed product term layout");
	end

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	cell_vec_t          pol_r;        // Low mode bit per cell, 1 = true output
	cell_vec_t          pol_nxt;      // Next polarity word
	cell_vec_t          mode_r;       // High mode bit per cell, 1 = combinatorial
	cell_vec_t          mode_nxt;     // Next mode word
	logic [23:0]        oesel_r;      // Two selector bits per cell
	logic [23:0]        oesel_nxt;    // Next selector word
	logic               ack_r;        // Second cycle of a bus access
	logic [`DATA_W-1:0] rdata_nxt;    // Read multiplexer
	cell_vec_t          pin_sync;     // Pin levels after two flip-flops
	cell_vec_t          ff_q;         // Flip-flop state of every cell
	cell_vec_t          sum_vec;      // Sum term of every cell
	logic               clr;          // Combined asynchronous clear
	logic               req;          // Any bus access pending
	logic               wr_en;        // Write commits this edge
	logic               rd_load;      // Read data captured this edge
	logic [`DATA_W-1:0] be_mask;      // Byte enables widened to bits
	logic               hit_pol;      // Address decodes
	logic               hit_mode;
	logic               hit_oesel;
	logic               hit_state;
	logic               hit_pins;

	////////////////////////////////////////////////////////////////////////////
	// Shared control terms

	// Power-up reset and the shared clear term both clear every macrocell flip-flop
	assign clr = rst | async_zero_term;

	// Pins come from the board, so they are synchronised before feedback
	sync_two_flop #(
		.WIDTH(`CELL_COUNT)
	) u_pin_sync (
		.core_clk(core_clk),
		.rst     (rst),
		.din     (pin_in),
		.dout    (pin_sync)
	);

	////////////////////////////////////////////////////////////////////////////
	// Macrocells

	// One cell per output, each slicing its own share of the term bus
	for (genvar i = 0; i < NCELLS; i++) begin : g_cell
		localparam int W = term_cnt(i);
		localparam int O = term_off(i);
		output_macrocell #(
			.NTERMS(W)
		) u_cell (
			.core_clk     (core_clk),
			.clr          (clr),
			.sync_set     (sync_set_term),
			.terms        (logic_terms[O +: W]),
			.oe_term      (oe_terms[i]),
			.mode_bit_low (pol_r[i]),
			.mode_bit_high(mode_r[i]),
			.oe_sel       (oe_sel_e'(oesel_r[2*i +: 2])),
			.pin_level    (pin_sync[i]),
			.q            (ff_q[i]),
			.sum          (sum_vec[i]),
			.pin_out      (pin_out[i]),
			.pin_oe       (pin_oe[i]),
			.fb_true      (feedback_true[i]),
			.fb_comp      (feedback_comp[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave

	// Every access waits exactly one cycle, so the answer time is fixed
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_r;
	assign wr_en           = avs_write & ack_r;
	assign rd_load         = avs_read & ~ack_r;

	// Address decode; unmapped addresses read zero and ignore writes
	assign hit_pol   = (avs_address == `REG_POL);
	assign hit_mode  = (avs_address == `REG_MODE);
	assign hit_oesel = (avs_address == `REG_OESEL);
	assign hit_state = (avs_address == `REG_STATE);
	assign hit_pins  = (avs_address == `REG_PINS);

	// Byte enables widened to a bit mask
	assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// Merge of written bytes into the configuration words
	assign pol_nxt   = cell_vec_t'((32'(pol_r) & ~be_mask) | (avs_writedata & be_mask));
	assign mode_nxt  = cell_vec_t'((32'(mode_r) & ~be_mask) | (avs_writedata & be_mask));
	assign oesel_nxt = 24'((32'(oesel_r) & ~be_mask) | (avs_writedata & be_mask));

	// Read multiplexer; state and pin words show the cells' own activity
	assign rdata_nxt = hit_pol   ? 32'(pol_r) :
	                   hit_mode  ? 32'(mode_r) :
	                   hit_oesel ? 32'(oesel_r) :
	                   hit_state ? 32'(ff_q) :
	                   hit_pins  ? ((32'(pin_oe) << `PINS_OE_LSB) | 32'(pin_out)) :
	                   32'h0000_0000;

	// Access phase tracker
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	// Read data are captured in the waiting cycle and stand afterwards
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (rd_load) begin
			avs_readdata <= rdata_nxt;
		end
	end

	// Configuration words; polarity and mode are the two mode bits
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pol_r   <= `POL_RST;
			mode_r  <= `MODE_RST;
			oesel_r <= `OESEL_RST;
		end else if (wr_en) begin
			if (hit_pol) begin
				pol_r <= pol_nxt;
			end
			if (hit_mode) begin
				mode_r <= mode_nxt;
			end
			if (hit_oesel) begin
				oesel_r <= oesel_nxt;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	cell_vec_t reg_mask;  // Cells in registered mode
	cell_vec_t comb_mask; // Cells in combinatorial mode
	cell_vec_t off_mask;  // Combinatorial cells forced off
	assign reg_mask  = ~mode_r;
	assign comb_mask = mode_r;
	for (genvar j = 0; j < NCELLS; j++) begin : g_off
		assign off_mask[j] = mode_r[j] & (oesel_r[2*j +: 2] == `OE_CODE_OFF);
	end

	// Clear term holds every flip-flop at zero
	AST_CLR_ZERO: assert property (@(posedge core_clk) disable iff (rst)
		async_zero_term |-> (ff_q == '0))
		else $error("flip-flops not cleared while clear term is high");

	// Preset without clear gives all ones after one edge
	AST_PRESET_ONES: assert property (@(posedge core_clk) disable iff (rst)
		(sync_set_term && !async_zero_term) ##1 !async_zero_term
		|-> (ff_q == '1))
		else $error("preset did not load ones");

	// Flip-flops take the sum term of the previous cycle
	AST_CAPTURE: assert property (@(posedge core_clk) disable iff (rst)
		!sync_set_term && !async_zero_term ##1 !async_zero_term
		|-> (ff_q == $past(sum_vec)))
		else $error("flip-flop did not capture its sum term");

	// Registered pins show the captured state through the polarity
	AST_REG_PIN: assert property (@(posedge core_clk) disable iff (rst)
		!sync_set_term && !async_zero_term ##1 (!async_zero_term && $stable(pol_r))
		|-> (((pin_out ^ ~pol_r) & reg_mask) == ($past(sum_vec) & reg_mask)))
		else $error("registered pin does not follow flip-flop");

	// Clear shows as the polarity level on registered pins
	AST_CLR_PIN: assert property (@(posedge core_clk) disable iff (rst)
		async_zero_term |-> ((pin_out & reg_mask) == (~pol_r & reg_mask)))
		else $error("pin level after clear ignores polarity");

	// Combinatorial pins follow the sum in the same cycle
	AST_COMB_PIN: assert property (@(posedge core_clk) disable iff (rst)
		((pin_out ^ ~pol_r) & comb_mask) == (sum_vec & comb_mask))
		else $error("combinatorial pin does not follow sum term");

	// Registered pins are enabled by their own term only
	AST_REG_OE: assert property (@(posedge core_clk) disable iff (rst)
		(pin_oe & reg_mask) == (oe_terms & reg_mask))
		else $error("registered enable not equal to its term");

	// Combinatorial cells set off never drive
	AST_COMB_OFF: assert property (@(posedge core_clk) disable iff (rst)
		(pin_oe & off_mask) == '0)
		else $error("input-only cell is driving");

	// Registered feedback is the inverted state
	AST_REG_FB: assert property (@(posedge core_clk) disable iff (rst)
		((feedback_true & reg_mask) == (~ff_q & reg_mask))
		&& (feedback_comp == ~feedback_true))
		else $error("registered feedback not from inverted state");

	// Combinatorial feedback is the pin level two cycles later
	AST_COMB_FB: assert property (@(posedge core_clk) disable iff (rst)
		$stable(mode_r) ##1 $stable(mode_r)
		|-> ((feedback_true & comb_mask) == ($past(pin_in, 2) & comb_mask)))
		else $error("combinatorial feedback not from pin");

	// Each access waits one cycle and is then answered
	AST_BUS_WAIT: assert property (@(posedge core_clk) disable iff (rst)
		(req && !ack_r) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not one cycle after request");

	// Main scenarios
	COV_PRESET: cover property (@(posedge core_clk) disable iff (rst)
		sync_set_term && !async_zero_term ##1 (ff_q == '1));
	COV_CLEAR: cover property (@(posedge core_clk) disable iff (rst)
		(ff_q != '0) ##1 async_zero_term);
	COV_BIDIR: cover property (@(posedge core_clk) disable iff (rst)
		(comb_mask != '0) && ((pin_oe & comb_mask) != '0));
	COV_READ: cover property (@(posedge core_clk) disable iff (rst)
		avs_read && hit_state && !avs_waitrequest);

endmodule : pld_output_macrocell_bank
`default_nettype wire

// ### board_pin_model.sv
// Board side of the pins: resolves each pin level from device drive, board drive and pull-up
`timescale 1ns/1ps
`default_nettype none

module board_pin_model (
	input  wire logic [11:0] pin_out,   // Device drive value
	input  wire logic [11:0] pin_oe,    // Device drives where high
	input  wire logic [11:0] brd_val,   // Board drive value
	input  wire logic [11:0] brd_en,    // Board drives where high
	output logic      [11:0] pin_level  // Level seen on each pin
);
	////////////////////////////////////////////////////////////////////////////////
	// Device wins where it drives; an undriven pin floats high on its pull-up,
	// so a released pin never keeps showing the last driven value
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & brd_en & brd_val) | (~pin_oe & ~brd_en);
endmodule : board_pin_model
`default_nettype wire

// ### pld_output_macrocell_bank_tb.sv
// Self-checking bench for the output macrocell bank
`timescale 1ns/1ps
`default_nettype none
`include "macrocell_cfg.svh"

module pld_output_macrocell_bank_tb;
	import macrocell_pkg::*;
	logic         core_clk, rst, avs_read, avs_write, async_zero_term, sync_set_term;
	logic [7:0]   avs_address;
	logic [31:0]  avs_writedata, avs_readdata, rdv;
	logic [3:0]   avs_byteenable;
	logic         avs_waitrequest;
	logic [107:0] logic_terms, lt;
	cell_vec_t    oe_terms, pin_in, pin_out, pin_oe, feedback_true, feedback_comp;
	logic [11:0]  brd_val, brd_en;
	int           bad_count, total_checks;

	////////////////////////////////////////////////////////////////////////////////
	// Design and board model
	pld_output_macrocell_bank i_pld_output_macrocell_bank (.core_clk(core_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.logic_terms(logic_terms), .oe_terms(oe_terms), .async_zero_term(async_zero_term),
		.sync_set_term(sync_set_term), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.feedback_true(feedback_true), .feedback_comp(feedback_comp));
	board_pin_model i_board_pin_model (.pin_out(pin_out), .pin_oe(pin_oe),
		.brd_val(brd_val), .brd_en(brd_en), .pin_level(pin_in));

	// 250 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Bus cycle: hold until waitrequest is seen low at a rising edge, then release
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= ~wr;
		// Values read right after the edge are those the design sampled there
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		rdv = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge core_clk);
	endtask : bus

	// Read a register and compare it
	task rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk("readdata", rdv, exp);
	endtask : rchk

	// One product term of a cell: lowest or highest of its group
	function automatic logic [107:0] term_bit(input int i, input int top);
		int b[12] = '{0, 12, 24, 34, 44, 52, 60, 68, 76, 84, 92, 100};
		int w[12] = '{12, 12, 10, 10, 8, 8, 8, 8, 8, 8, 8, 8};
		term_bit = '0;
		term_bit[b[i] + (top ? w[i] - 1 : 0)] = 1'b1;
	endfunction : term_bit

	// Verdict and end of run
	task results;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	// Watchdog well past the expected run length
	initial begin
		repeat (5000) @(posedge core_clk);
		bad_count++;
		results();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h00;
		avs_writedata = '0; avs_byteenable = 4'hF; logic_terms = '0; oe_terms = 12'hA5A;
		async_zero_term = 1'b0; sync_set_term = 1'b0; brd_val = '0; brd_en = '0;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		// Reset state, register defaults, unmapped and read-only places
		@(negedge core_clk);
		chk("pin_out", pin_out, 12'hFFF);
		chk("pin_oe", pin_oe, 12'hA5A);
		@(posedge core_clk);
		rchk(`REG_POL, 0);
		rchk(`REG_MODE, 0);
		rchk(`REG_OESEL, 0);
		rchk(`REG_STATE, 0);
		rchk(8'hFC, 0);
		bus(1'b1, `REG_STATE, 32'h0000_0FFF);
		rchk(`REG_STATE, 0);
		$display("test reset done");
		// Registered capture, enable term and feedback
		bus(1'b1, `REG_POL, 32'h0000_0FFF);
		lt = '0;
		for (int i = 0; i < 12; i += 2) lt |= term_bit(i, 0);
		logic_terms <= lt;
		oe_terms    <= 12'h000;
		brd_en      <= 12'hFFF;
		@(negedge core_clk);
		chk("pin_out", pin_out, 12'h000);
		@(posedge core_clk);
		@(negedge core_clk);
		chk("pin_out", pin_out, 12'h555);
		chk("pin_oe", pin_oe, 12'h000);
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk("fb_true", feedback_true, 12'hAAA);
		chk("fb_comp", feedback_comp, 12'h555);
		@(posedge core_clk);
		$display("test registered done");
		// Shared clear acts before the next edge, ahead of polarity
		async_zero_term <= 1'b1;
		@(negedge core_clk);
		chk("pin_out", pin_out, 12'h000);
		@(posedge core_clk);
		bus(1'b1, `REG_POL, 32'h0000_0000);
		@(negedge core_clk);
		chk("pin_out", pin_out, 12'hFFF);
		@(posedge core_clk);
		async_zero_term <= 1'b0;
		logic_terms     <= '0;
		repeat (2) @(posedge core_clk);
		// Shared preset loads ones at the next edge only
		sync_set_term <= 1'b1;
		@(negedge core_clk);
		chk("pin_out", pin_out, 12'hFFF);
		@(posedge core_clk);
		sync_set_term <= 1'b0;
		@(negedge core_clk);
		chk("pin_out", pin_out, 12'h000);
		@(posedge core_clk);
		@(negedge core_clk);
		chk("pin_out", pin_out, 12'hFFF);
		@(posedge core_clk);
		$display("test clear preset done");
		// Term count per cell in combinatorial mode, highest term of each group
		bus(1'b1, `REG_MODE, 32'h0000_0FFF);
		bus(1'b1, `REG_POL, 32'h0000_0FFF);
		bus(1'b1, `REG_OESEL, 32'h0055_5555);
		for (int i = 0; i < 12; i++) begin
			logic_terms <= term_bit(i, 1);
			@(negedge core_clk);
			chk("pin_out", pin_out, 32'h1 << i);
			@(posedge core_clk);
		end
		bus(1'b1, `REG_POL, 32'h0000_0000);
		logic_terms <= term_bit(0, 0);
		@(negedge core_clk);
		chk("pin_out", pin_out, 12'hFFE);
		chk("pin_oe", pin_oe, 12'hFFF);
		@(posedge core_clk);
		$display("test combinatorial done");
		// Enable selector codes and pin feedback
		bus(1'b1, `REG_OESEL, 32'h00E4_E4E4);
		oe_terms <= 12'h00F;
		brd_val  <= 12'h0F0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk("pin_oe", pin_oe, 12'h223);
		chk("fb_true", feedback_true, 12'h2F2);
		chk("fb_comp", feedback_comp, 12'hD0D);
		@(posedge core_clk);
		brd_en <= 12'h000;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk("fb_true", feedback_true, 12'hFFE);
		@(posedge core_clk);
		$display("test enable feedback done");
		results();
	end
endmodule : pld_output_macrocell_bank_tb
`default_nettype wire
